// ### hw/alu_exec_params.svh
`ifndef ALU_EXEC_PARAMS_SVH
`define ALU_EXEC_PARAMS_SVH
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAGS_RST 8'h00
`define PC_RST 22'h000000
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_FOUR 3'h4
`define ALL_ONES 8'hff
`endif

// ### hw/alu_exec_pkg.sv
package alu_exec_pkg;
    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR,
        OP_SBR, OP_CBR, OP_TST, OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE,
        OP_MUL, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT, OP_FRACTIONAL_PRODUCT, OP_FRACTIONAL_SIGNED_PRODUCT, OP_FRACTIONAL_MIXED_PRODUCT,
        OP_RELATIVE_GOTO, OP_RELATIVE_SUBROUTINE_ENTRY, OP_POINTER_GOTO, OP_EXTENDED_POINTER_GOTO, OP_POINTER_SUBROUTINE_ENTRY, OP_NOP
    } op_e;

    typedef struct packed {
        op_e         op;
        logic        use_const;
        logic [7:0]  dst;
        logic [7:0]  src;
        logic [7:0]  dst_hi;
        logic [7:0]  konst;
        logic [11:0] offset;
        logic [15:0] zptr;
        logic [5:0]  ext_page;
        logic [21:0] pc;
    } req_s;

    typedef struct packed {
        logic        wr_byte;
        logic        wr_word;
        logic        wr_pair;
        logic [7:0]  byte_val;
        logic [15:0] word_val;
        logic [7:0]  flags;
        logic [7:0]  flag_mask;
    } res_s;
endpackage : alu_exec_pkg

// ### hw/alu_mul_unit.sv
`timescale 1ns/1ns
`default_nettype none
module alu_mul_unit (
    input  wire logic [7:0]  a_i,
    input  wire logic [7:0]  b_i,
    input  wire logic        a_signed_i,
    input  wire logic        b_signed_i,
    input  wire logic        frac_i,
    output logic      [15:0] prod_o,
    output logic             carry_o
);
    logic signed [17:0] raw;
    always_comb begin
        raw   = $signed({a_signed_i & a_i[7], a_i}) * $signed({b_signed_i & b_i[7], b_i});
        // Carry is bit 15 before the fractional shift
        carry_o = raw[15];
        prod_o  = frac_i ? {raw[14:0], 1'b0} : raw[15:0];
    end
endmodule : alu_mul_unit
`default_nettype wire

// ### hw/alu_exec.sv
// Contract
// - Add registers, optionally with carry; Z,C,N,V,H; one cycle.
// - Word add immediate on pair; Z,C,N,V,S; two cycles.
// - Subtract register or constant; Z,C,N,V,H; one cycle.
// - Subtract with borrow also subtracts carry; same flags; one cycle.
// - Word subtract immediate on pair; Z,C,N,V,S; two cycles.
// - AND with register or constant; Z,N,V; one cycle.
// - OR with register or constant; Z,N,V; one cycle.
// - Exclusive OR of registers; Z,N,V; one cycle.
// - Set mask bits ORs constant in; Z,N,V; one cycle.
// - Clear mask bits ANDs with all-ones minus mask; Z,N,V.
// - Zero/minus check ANDs register with itself; Z,N,V; one cycle.
// - Integer products to pair one:zero; Z,C; two cycles.
// - Fractional products shifted left one; Z,C; two cycles.
// - Relative entry PC+k+1 four cycles; relative goto two cycles.
// - Pointer goto loads PC from Z; no flags; two cycles.
// - Extended pointer goto loads page:Z; no flags; two cycles.
// - Pointer entry loads PC from Z; no flags; four cycles.
`timescale 1ns/1ns
`default_nettype none
`include "alu_exec_params.svh"
module alu_exec #(
    parameter int PC_W = 22
) (
    input  wire logic                ref_clk_i,
    input  wire logic                nrst_i,
    input  wire logic                ce_i,
    input  wire logic                start_i,
    input  wire alu_exec_pkg::req_s  req_i,
    input  wire logic [7:0]          sreg_i,
    output logic                     busy_o,
    output logic                     done_o,
    output alu_exec_pkg::res_s       res_o,
    output logic                     push_o,
    output logic [PC_W-1:0]          ret_addr_o,
    output logic                     pc_load_o,
    output logic [PC_W-1:0]          pc_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT} state_e;

    typedef struct packed {
        state_e             st;
        logic [2:0]         left;
        logic               busy;
        logic               done;
        alu_exec_pkg::res_s res;
        logic               push;
        logic [PC_W-1:0]    ret;
        logic               pc_load;
        logic [PC_W-1:0]    pc;
        logic [PC_W-1:0]    pend_pc;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    function automatic logic [7:0] flags8(input logic [7:0] r, input logic c,
                                          input logic v, input logic h);
        logic [7:0] f;
        f = 8'h00;
        f[`FLAG_C] = c;
        f[`FLAG_Z] = (r == 8'h00);
        f[`FLAG_N] = r[7];
        f[`FLAG_V] = v;
        f[`FLAG_S] = r[7] ^ v;
        f[`FLAG_H] = h;
        return f;
    endfunction : flags8

    function automatic logic [7:0] fmask(input logic c, input logic z, input logic n,
                                         input logic v, input logic s, input logic h);
        logic [7:0] m;
        m = 8'h00;
        m[`FLAG_C] = c;
        m[`FLAG_Z] = z;
        m[`FLAG_N] = n;
        m[`FLAG_V] = v;
        m[`FLAG_S] = s;
        m[`FLAG_H] = h;
        return m;
    endfunction : fmask

    logic [7:0]  opb;
    logic        cin;
    logic [8:0]  sum9;
    logic [15:0] pair;
    logic [16:0] word17;
    logic [7:0]  logic_r;
    logic [15:0] prod;
    logic        prod_c;
    logic        m_as;
    logic        m_bs;
    logic        m_fr;
    logic [PC_W-1:0] rel_tgt;

    alu_mul_unit u_mul (
        .a_i        (req_i.dst),
        .b_i        (req_i.src),
        .a_signed_i (m_as),
        .b_signed_i (m_bs),
        .frac_i     (m_fr),
        .prod_o     (prod),
        .carry_o    (prod_c)
    );

    always_comb begin
        opb  = req_i.use_const ? req_i.konst : req_i.src;
        cin  = sreg_i[`FLAG_C];
        pair = {req_i.dst_hi, req_i.dst};
        m_as = req_i.op inside {alu_exec_pkg::OP_SIGNED_PRODUCT, alu_exec_pkg::OP_MIXED_SIGN_PRODUCT,
                                alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT, alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT};
        m_bs = req_i.op inside {alu_exec_pkg::OP_SIGNED_PRODUCT, alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT};
        m_fr = req_i.op inside {alu_exec_pkg::OP_FRACTIONAL_PRODUCT, alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT,
                                alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT};
        // PC + k + 1, k sign-extended from 12 bits
        rel_tgt = req_i.pc + PC_W'($signed(req_i.offset)) + PC_W'(1);
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.done    = 1'b0;
        nxt_st.push    = 1'b0;
        nxt_st.pc_load = 1'b0;
        nxt_st.res.wr_byte = 1'b0;
        nxt_st.res.wr_word = 1'b0;
        nxt_st.res.wr_pair = 1'b0;
        sum9    = 9'h000;
        word17  = 17'h00000;
        logic_r = 8'h00;
        case (st_ff.st)
            ST_IDLE: begin
                if (start_i) begin
                    nxt_st.left = `CYC_ONE;
                    case (req_i.op)
                        alu_exec_pkg::OP_ADD, alu_exec_pkg::OP_ADC: begin
                            sum9 = {1'b0, req_i.dst} + {1'b0, opb}
                                 + {8'h00, (req_i.op == alu_exec_pkg::OP_ADC) & cin};
                            nxt_st.res.byte_val = sum9[7:0];
                            nxt_st.res.flags = flags8(sum9[7:0], sum9[8],
                                (req_i.dst[7] == opb[7]) && (sum9[7] != req_i.dst[7]), 1'b0);
                            nxt_st.res.flags[`FLAG_H] =
                                (req_i.dst[3] & opb[3]) | (opb[3] & ~sum9[3])
                                | (~sum9[3] & req_i.dst[3]);
                            nxt_st.res.flag_mask = fmask(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
                            nxt_st.res.wr_byte = 1'b1;
                        end
                        alu_exec_pkg::OP_SUB, alu_exec_pkg::OP_SBC: begin
                            sum9 = {1'b0, req_i.dst} - {1'b0, opb}
                                 - {8'h00, (req_i.op == alu_exec_pkg::OP_SBC) & cin};
                            nxt_st.res.byte_val = sum9[7:0];
                            nxt_st.res.flags = flags8(sum9[7:0], sum9[8],
                                (req_i.dst[7] != opb[7]) && (sum9[7] != req_i.dst[7]), 1'b0);
                            nxt_st.res.flags[`FLAG_H] =
                                (~req_i.dst[3] & opb[3]) | (opb[3] & sum9[3])
                                | (sum9[3] & ~req_i.dst[3]);
                            // Borrow chain keeps Z sticky across multi-byte subtracts
                            if (req_i.op == alu_exec_pkg::OP_SBC) begin
                                nxt_st.res.flags[`FLAG_Z] =
                                    (sum9[7:0] == 8'h00) & sreg_i[`FLAG_Z];
                            end
                            nxt_st.res.flag_mask = fmask(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
                            nxt_st.res.wr_byte = 1'b1;
                        end
                        alu_exec_pkg::OP_AND, alu_exec_pkg::OP_OR, alu_exec_pkg::OP_EOR,
                        alu_exec_pkg::OP_SBR, alu_exec_pkg::OP_CBR,
                        alu_exec_pkg::OP_TST: begin
                            case (req_i.op)
                                alu_exec_pkg::OP_AND: logic_r = req_i.dst & opb;
                                alu_exec_pkg::OP_OR:  logic_r = req_i.dst | opb;
                                alu_exec_pkg::OP_EOR: logic_r = req_i.dst ^ req_i.src;
                                alu_exec_pkg::OP_SBR: logic_r = req_i.dst | req_i.konst;
                                alu_exec_pkg::OP_CBR:
                                    logic_r = req_i.dst & (`ALL_ONES - req_i.konst);
                                alu_exec_pkg::OP_TST: logic_r = req_i.dst & req_i.dst;
                                default: logic_r = 8'h00;
                            endcase
                            nxt_st.res.byte_val  = logic_r;
                            nxt_st.res.flags     = flags8(logic_r, 1'b0, 1'b0, 1'b0);
                            nxt_st.res.flag_mask = fmask(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
                            nxt_st.res.wr_byte   = 1'b1;
                        end
                        alu_exec_pkg::OP_WORD_ADD_IMMEDIATE, alu_exec_pkg::OP_WORD_SUB_IMMEDIATE: begin
                            if (req_i.op == alu_exec_pkg::OP_WORD_ADD_IMMEDIATE) begin
                                word17 = {1'b0, pair} + {9'h000, req_i.konst};
                            end else begin
                                word17 = {1'b0, pair} - {9'h000, req_i.konst};
                            end
                            nxt_st.res.word_val = word17[15:0];
                            nxt_st.res.flags = 8'h00;
                            nxt_st.res.flags[`FLAG_C] = word17[16];
                            nxt_st.res.flags[`FLAG_Z] = (word17[15:0] == 16'h0000);
                            nxt_st.res.flags[`FLAG_N] = word17[15];
                            nxt_st.res.flags[`FLAG_V] = (req_i.op == alu_exec_pkg::OP_WORD_ADD_IMMEDIATE)
                                ? (~pair[15] & word17[15]) : (pair[15] & ~word17[15]);
                            nxt_st.res.flags[`FLAG_S] = word17[15] ^
                                nxt_st.res.flags[`FLAG_V];
                            nxt_st.res.flag_mask = fmask(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
                            nxt_st.left = `CYC_TWO;
                        end
                        alu_exec_pkg::OP_MUL, alu_exec_pkg::OP_SIGNED_PRODUCT, alu_exec_pkg::OP_MIXED_SIGN_PRODUCT,
                        alu_exec_pkg::OP_FRACTIONAL_PRODUCT, alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT,
                        alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT: begin
                            nxt_st.res.word_val = prod;
                            nxt_st.res.flags = 8'h00;
                            nxt_st.res.flags[`FLAG_C] = prod_c;
                            nxt_st.res.flags[`FLAG_Z] = (prod == 16'h0000);
                            nxt_st.res.flag_mask = fmask(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
                            nxt_st.left = `CYC_TWO;
                        end
                        alu_exec_pkg::OP_RELATIVE_GOTO: begin
                            nxt_st.pend_pc = rel_tgt;
                            nxt_st.res.flag_mask = 8'h00;
                            nxt_st.left = `CYC_TWO;
                        end
                        alu_exec_pkg::OP_RELATIVE_SUBROUTINE_ENTRY: begin
                            nxt_st.pend_pc = rel_tgt;
                            nxt_st.res.flag_mask = 8'h00;
                            nxt_st.left = `CYC_FOUR;
                        end
                        alu_exec_pkg::OP_POINTER_GOTO: begin
                            nxt_st.pend_pc = PC_W'(req_i.zptr);
                            nxt_st.res.flag_mask = 8'h00;
                            nxt_st.left = `CYC_TWO;
                        end
                        alu_exec_pkg::OP_EXTENDED_POINTER_GOTO: begin
                            nxt_st.pend_pc = PC_W'({req_i.ext_page, req_i.zptr});
                            nxt_st.res.flag_mask = 8'h00;
                            nxt_st.left = `CYC_TWO;
                        end
                        alu_exec_pkg::OP_POINTER_SUBROUTINE_ENTRY: begin
                            nxt_st.pend_pc = PC_W'(req_i.zptr);
                            nxt_st.res.flag_mask = 8'h00;
                            nxt_st.left = `CYC_FOUR;
                        end
                        default: begin
                            nxt_st.res.flag_mask = 8'h00;
                        end
                    endcase
                    // Return address is the word after the call
                    if (req_i.op inside {alu_exec_pkg::OP_RELATIVE_SUBROUTINE_ENTRY, alu_exec_pkg::OP_POINTER_SUBROUTINE_ENTRY}) begin
                        nxt_st.push = 1'b1;
                        nxt_st.ret  = req_i.pc + PC_W'(1);
                    end
                    if (nxt_st.left == `CYC_ONE) begin
                        nxt_st.done = 1'b1;
                    end else begin
                        nxt_st.st   = ST_WAIT;
                        nxt_st.busy = 1'b1;
                        nxt_st.left = nxt_st.left - 3'h1;
                    end
                end
            end
            ST_WAIT: begin
                nxt_st.left = st_ff.left - 3'h1;
                if (st_ff.left == 3'h1) begin
                    // Results land on the last cycle, after any push
                    nxt_st.st   = ST_IDLE;
                    nxt_st.busy = 1'b0;
                    nxt_st.done = 1'b1;
                    if (st_ff.res.flag_mask == 8'h00) begin
                        nxt_st.pc_load = 1'b1;
                        nxt_st.pc = st_ff.pend_pc;
                    end else if (st_ff.res.flag_mask[`FLAG_S]) begin
                        nxt_st.res.wr_word = 1'b1;
                    end else begin
                        nxt_st.res.wr_pair = 1'b1;
                    end
                end
            end
            default: nxt_st.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            st_ff <= '0;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        busy_o     = st_ff.busy;
        done_o     = st_ff.done;
        res_o      = st_ff.res;
        push_o     = st_ff.push;
        ret_addr_o = st_ff.ret;
        pc_load_o  = st_ff.pc_load;
        pc_o       = st_ff.pc;
    end

    property p_call_push_first;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && start_i && !st_ff.busy && req_i.op == alu_exec_pkg::OP_RELATIVE_SUBROUTINE_ENTRY)
        |=> push_o;
    endproperty
    a_call_push_first: assert property (p_call_push_first) else $error("no push");

    property p_one_cycle;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && start_i && !st_ff.busy && req_i.op == alu_exec_pkg::OP_ADD)
        |=> (done_o && res_o.wr_byte && !busy_o);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("add not one cycle");

    property p_logic_mask;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        res_o.wr_byte && !res_o.flag_mask[`FLAG_C] |-> res_o.flag_mask[`FLAG_Z];
    endproperty
    a_logic_mask: assert property (p_logic_mask) else $error("logic mask");

    property p_word_two;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && start_i && !st_ff.busy && req_i.op == alu_exec_pkg::OP_WORD_ADD_IMMEDIATE)
        |=> busy_o ##1 (done_o && res_o.wr_word && !busy_o);
    endproperty
    a_word_two: assert property (p_word_two) else $error("word add not two cycles");

    property p_mul_two;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && start_i && !st_ff.busy && req_i.op == alu_exec_pkg::OP_MUL)
        |=> busy_o ##1 (done_o && res_o.wr_pair && !busy_o);
    endproperty
    a_mul_two: assert property (p_mul_two) else $error("product not two cycles");

    property p_ptr_entry_four;
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (ce_i && start_i && !st_ff.busy && req_i.op == alu_exec_pkg::OP_POINTER_SUBROUTINE_ENTRY)
        |=> (push_o && busy_o) ##3 (pc_load_o && done_o && !busy_o);
    endproperty
    a_ptr_entry_four: assert property (p_ptr_entry_four) else $error("entry not four cycles");
endmodule : alu_exec
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    typedef struct {
        logic [7:0]  b;
        logic [15:0] w;
        logic [7:0]  f;
        logic [7:0]  m;
        logic [21:0] pc;
        int          cyc;
        int          kind;
    } exp_s;

    logic               ref_clk_i;
    logic               nrst_i;
    logic               ce_i;
    logic               start_i;
    alu_exec_pkg::req_s req_i;
    logic [7:0]         sreg_i;
    logic               busy_o;
    logic               done_o;
    logic               push_o;
    logic               pc_load_o;
    alu_exec_pkg::res_s res_o;
    logic [21:0]        ret_addr_o;
    logic [21:0]        pc_o;
    int                 error_cnt;
    int                 total_checks;
    int unsigned        seed_v;
    alu_exec_pkg::req_s rq;
    logic [7:0]         sr_v;
    exp_s               ex;

    alu_exec #(.PC_W(22)) dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
        .start_i(start_i), .req_i(req_i), .sreg_i(sreg_i), .busy_o(busy_o),
        .done_o(done_o), .res_o(res_o), .push_o(push_o), .ret_addr_o(ret_addr_o),
        .pc_load_o(pc_load_o), .pc_o(pc_o));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        total_checks++;
        if (seen !== expv) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : chk

    task automatic end_sim();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    function automatic exp_s model(input alu_exec_pkg::req_s r, input logic [7:0] sr);
        exp_s        e;
        logic [7:0]  d;
        logic [7:0]  s;
        logic [7:0]  x;
        logic [15:0] w;
        logic        add;
        int          pa;
        int          pb;
        int          p;
        e = '{default: 0};
        d = r.dst;
        s = r.use_const ? r.konst : r.src;
        x = 8'h00;
        e.cyc = 1;
        e.m = 8'h0e;
        add = (r.op == alu_exec_pkg::OP_WORD_ADD_IMMEDIATE);
        case (r.op)
            alu_exec_pkg::OP_ADD, alu_exec_pkg::OP_ADC: begin
                x = d + s + 8'(r.op == alu_exec_pkg::OP_ADC && sr[0]);
                e.m = 8'h2f;
                e.f[0] = d[7] & s[7] | s[7] & ~x[7] | ~x[7] & d[7];
                e.f[3] = d[7] & s[7] & ~x[7] | ~d[7] & ~s[7] & x[7];
                e.f[5] = d[3] & s[3] | s[3] & ~x[3] | ~x[3] & d[3];
            end
            alu_exec_pkg::OP_SUB, alu_exec_pkg::OP_SBC: begin
                x = d - s - 8'(r.op == alu_exec_pkg::OP_SBC && sr[0]);
                e.m = 8'h2f;
                e.f[0] = ~d[7] & s[7] | s[7] & x[7] | x[7] & ~d[7];
                e.f[3] = d[7] & ~s[7] & ~x[7] | ~d[7] & s[7] & x[7];
                e.f[5] = ~d[3] & s[3] | s[3] & x[3] | x[3] & ~d[3];
            end
            alu_exec_pkg::OP_AND: x = d & s;
            alu_exec_pkg::OP_OR, alu_exec_pkg::OP_SBR: x = d | s;
            alu_exec_pkg::OP_EOR: x = d ^ s;
            alu_exec_pkg::OP_CBR: x = d & (8'hff - r.konst);
            alu_exec_pkg::OP_TST: begin
                x = d;
                e.kind = 4;
            end
            alu_exec_pkg::OP_WORD_ADD_IMMEDIATE, alu_exec_pkg::OP_WORD_SUB_IMMEDIATE: begin
                w = add ? {r.dst_hi, d} + 16'(r.konst) : {r.dst_hi, d} - 16'(r.konst);
                e.f[0] = add ? ~w[15] & r.dst_hi[7] : w[15] & ~r.dst_hi[7];
                e.f[3] = add ? ~r.dst_hi[7] & w[15] : r.dst_hi[7] & ~w[15];
                e.f[2] = w[15];
                e.f[1] = (w == 16'h0000);
                e.f[4] = e.f[2] ^ e.f[3];
                e.w = w;
                e.m = 8'h1f;
                e.cyc = 2;
                e.kind = 1;
            end
            default: begin
                if (r.op <= alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT) begin
                    pa = (r.op inside {alu_exec_pkg::OP_SIGNED_PRODUCT, alu_exec_pkg::OP_MIXED_SIGN_PRODUCT,
                        alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT, alu_exec_pkg::OP_FRACTIONAL_MIXED_PRODUCT}) ?
                        int'($signed(d)) : int'(d);
                    pb = (r.op inside {alu_exec_pkg::OP_SIGNED_PRODUCT, alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT}) ?
                        int'($signed(r.src)) : int'(r.src);
                    p = pa * pb;
                    w = p[15:0];
                    e.f[0] = w[15];
                    if (r.op >= alu_exec_pkg::OP_FRACTIONAL_PRODUCT) begin
                        w = w << 1;
                    end
                    e.w = w;
                    e.f[1] = (w == 16'h0000);
                    e.m = 8'h03;
                    e.cyc = 2;
                    e.kind = 2;
                end else begin
                    e.kind = 3;
                    e.m = 8'h00;
                    e.cyc = (r.op inside {alu_exec_pkg::OP_RELATIVE_SUBROUTINE_ENTRY, alu_exec_pkg::OP_POINTER_SUBROUTINE_ENTRY}) ? 4 : 2;
                    if (r.op inside {alu_exec_pkg::OP_RELATIVE_GOTO, alu_exec_pkg::OP_RELATIVE_SUBROUTINE_ENTRY}) begin
                        e.pc = r.pc + {{10{r.offset[11]}}, r.offset} + 22'h000001;
                    end else if (r.op == alu_exec_pkg::OP_EXTENDED_POINTER_GOTO) begin
                        e.pc = {r.ext_page, r.zptr};
                    end else begin
                        e.pc = {6'h00, r.zptr};
                    end
                end
            end
        endcase
        if (e.kind == 0 || e.kind == 4) begin
            e.b = x;
            e.f[2] = x[7];
            e.f[1] = (x == 8'h00) && (r.op != alu_exec_pkg::OP_SBC || sr[1]);
        end
        return e;
    endfunction : model

    function automatic alu_exec_pkg::req_s rnd_req(input alu_exec_pkg::op_e op);
        alu_exec_pkg::req_s r;
        logic [95:0]        v;
        v = {$urandom, $urandom, $urandom};
        r = v[93:0];
        r.op = op;
        r.use_const = r.use_const & (op inside {alu_exec_pkg::OP_SUB, alu_exec_pkg::OP_SBC,
            alu_exec_pkg::OP_AND, alu_exec_pkg::OP_OR}) |
            (op inside {alu_exec_pkg::OP_SBR, alu_exec_pkg::OP_CBR});
        // Word immediates are six bits wide in the instruction word
        if (op inside {alu_exec_pkg::OP_WORD_ADD_IMMEDIATE, alu_exec_pkg::OP_WORD_SUB_IMMEDIATE}) begin
            r.konst = {2'b00, r.konst[5:0]};
        end
        return r;
    endfunction : rnd_req

    task automatic cmp_res(input exp_s e);
        chk(done_o, 1'b1);
        chk(busy_o, 1'b0);
        case (e.kind)
            0, 4: begin
                chk(res_o.wr_byte, 1'b1);
                chk(res_o.byte_val, e.b);
            end
            1: begin
                chk(res_o.wr_word, 1'b1);
                chk(res_o.word_val, e.w);
            end
            2: begin
                chk(res_o.wr_pair, 1'b1);
                chk(res_o.word_val, e.w);
            end
            3: begin
                chk({res_o.wr_byte, res_o.wr_word, res_o.wr_pair}, 3'b000);
                chk(pc_load_o, 1'b1);
                chk(pc_o, e.pc);
            end
            default: ;
        endcase
        if (e.kind != 3) begin
            chk(res_o.flag_mask, e.m);
            chk(res_o.flags & e.m, e.f & e.m);
        end
    endtask : cmp_res

    task automatic run(input alu_exec_pkg::req_s r, input logic [7:0] sr);
        exp_s        e;
        int          n;
        int          np;
        logic [21:0] ra;
        e = model(r, sr);
        np = -1;
        ra = 22'h000000;
        req_i = r;
        sreg_i = sr;
        start_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        // A multi-cycle op keeps start up one more edge to see it refused
        start_i = (e.cyc > 1);
        req_i.op = alu_exec_pkg::OP_ADD;
        chk(busy_o, e.cyc > 1);
        n = 0;
        while (done_o !== 1'b1 && n < 8) begin
            if (push_o === 1'b1 && np < 0) begin
                np = n;
                ra = ret_addr_o;
            end
            @(posedge ref_clk_i);
            #1;
            start_i = 1'b0;
            n++;
        end
        chk(n, e.cyc - 1);
        chk(np, (e.kind == 3 && e.cyc == 4) ? 0 : -1);
        chk(ra, (np == 0) ? r.pc + 22'h000001 : 22'h000000);
        cmp_res(e);
        repeat (2) begin
            @(posedge ref_clk_i);
            #1;
            chk(done_o, 1'b0);
        end
    endtask : run

    task automatic dir(input alu_exec_pkg::op_e op, input logic [7:0] d, input logic [7:0] s,
                       input logic [7:0] k, input logic [7:0] sr);
        alu_exec_pkg::req_s r;
        r = rnd_req(op);
        r.dst = d;
        r.src = s;
        r.dst_hi = s;
        r.konst = k;
        r.use_const = (op inside {alu_exec_pkg::OP_SBR, alu_exec_pkg::OP_CBR});
        run(r, sr);
    endtask : dir

    initial begin
        #500000;
        error_cnt++;
        end_sim();
    end

    initial begin
        error_cnt = 0;
        total_checks = 0;
        ce_i = 1'b1;
        start_i = 1'b0;
        req_i = '0;
        sreg_i = 8'h00;
        nrst_i = 1'b0;
        seed_v = $urandom(32'hc65b);
        repeat (16) @(posedge ref_clk_i);
        #1;
        nrst_i = 1'b1;
        chk({busy_o, done_o, push_o, pc_load_o, |res_o}, 5'h00);
        // Clock enable low must swallow a request
        ce_i = 1'b0;
        start_i = 1'b1;
        req_i.op = alu_exec_pkg::OP_ADD;
        @(posedge ref_clk_i);
        #1;
        chk({busy_o, done_o}, 2'b00);
        ce_i = 1'b1;
        start_i = 1'b0;
        @(posedge ref_clk_i);
        #1;
        chk({busy_o, done_o}, 2'b00);
        dir(alu_exec_pkg::OP_ADD, 8'hff, 8'h01, 8'h00, 8'h00);
        dir(alu_exec_pkg::OP_SBC, 8'h05, 8'h05, 8'h00, 8'h00);
        dir(alu_exec_pkg::OP_SUB, 8'h80, 8'h01, 8'h00, 8'h00);
        dir(alu_exec_pkg::OP_WORD_ADD_IMMEDIATE, 8'hff, 8'hff, 8'h01, 8'h00);
        dir(alu_exec_pkg::OP_WORD_SUB_IMMEDIATE, 8'h00, 8'h00, 8'h01, 8'h00);
        dir(alu_exec_pkg::OP_CBR, 8'hff, 8'h00, 8'hff, 8'h00);
        dir(alu_exec_pkg::OP_FRACTIONAL_SIGNED_PRODUCT, 8'h80, 8'h80, 8'h00, 8'h00);
        for (int i = 0; i < 23; i++) begin
            repeat (12) run(rnd_req(alu_exec_pkg::op_e'(i)), 8'($urandom));
        end
        start_i = 1'b1;
        repeat (40) begin
            rq = rnd_req(alu_exec_pkg::op_e'($urandom % 10));
            sr_v = 8'($urandom);
            ex = model(rq, sr_v);
            req_i = rq;
            sreg_i = sr_v;
            @(posedge ref_clk_i);
            #1;
            cmp_res(ex);
        end
        start_i = 1'b0;
        @(posedge ref_clk_i);
        end_sim();
    end
endmodule : tb
`default_nettype wire
